// ===== ptcr_cfg.svh
// Register offsets, field positions and reset values of the control bank
`ifndef PTCR_CFG_SVH
`define PTCR_CFG_SVH

`define PTCR_ADDR_PORT_OPTION 8'h86
`define PTCR_ADDR_POWER_CONTROL 8'h87
`define PTCR_ADDR_TIMER_CTRL_REG 8'h88

`define PTCR_PORT_OPTION_PULLUP_BIT 0

`define PTCR_POWER_CONTROL_BAUD_DOUBLER_BIT 7
`define PTCR_POWER_CONTROL_FRAMING_CHECK_ENABLE_BIT 6
`define PTCR_POWER_CONTROL_POF_BIT 4
`define PTCR_POWER_CONTROL_GF1_BIT 3
`define PTCR_POWER_CONTROL_GF0_BIT 2
`define PTCR_POWER_CONTROL_PD_BIT 1
`define PTCR_POWER_CONTROL_IDL_BIT 0

`define PTCR_TIMER_CTRL_REG_TF1_BIT 7
`define PTCR_TIMER_CTRL_REG_TR1_BIT 6
`define PTCR_TIMER_CTRL_REG_TF0_BIT 5
`define PTCR_TIMER_CTRL_REG_TR0_BIT 4
`define PTCR_TIMER_CTRL_REG_IE1_BIT 3
`define PTCR_TIMER_CTRL_REG_IT1_BIT 2
`define PTCR_TIMER_CTRL_REG_IE0_BIT 1
`define PTCR_TIMER_CTRL_REG_IT0_BIT 0

`define PTCR_RST_BYTE 8'h00
`define PTCR_RST_BIT 1'b0
`define PTCR_PIN_IDLE 1'b1
`define PTCR_SER_MODE0 2'h0

`endif

// ===== ptcr_pkg.sv
// Types shared by the control register bank
`default_nettype none
package ptcr_pkg;
  typedef logic [7:0] ptcr_byte_t;
  typedef enum logic [2:0] {
    PTCR_RUN = 3'b001,
    PTCR_IDLE = 3'b010,
    PTCR_PDOWN = 3'b100
  } ptcr_pwr_e;
endpackage : ptcr_pkg
`default_nettype wire

// ===== ptcr_ext_if.sv
// Carrier between the bank and one external interrupt channel
`timescale 1ns/10ps
`default_nettype none
interface ptcr_ext_if;
  logic trig_sel;
  logic ack;
  logic sw_we;
  logic sw_val;
  logic flag;
  logic pin_low;
  modport chan (
    input trig_sel,
    input ack,
    input sw_we,
    input sw_val,
    output flag,
    output pin_low
  );
  modport ctl (
    output trig_sel,
    output ack,
    output sw_we,
    output sw_val,
    input flag,
    input pin_low
  );
endinterface : ptcr_ext_if
`default_nettype wire

// ===== ptcr_ext_chan.sv
// One external interrupt channel: pin filter, edge detect and request flag
`timescale 1ns/10ps
`default_nettype none
`include "ptcr_cfg.svh"
module ptcr_ext_chan (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  ptcr_ext_if.chan bus
);
  import ptcr_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic filt_ff;
  logic nxt_filt;
  logic fall;
  logic flag_ff;
  logic nxt_flag;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= `PTCR_PIN_IDLE;
      sync2_ff <= `PTCR_PIN_IDLE;
      sync3_ff <= `PTCR_PIN_IDLE;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A level counts only once two late stages agree
  always_comb begin
    nxt_filt = (sync2_ff == sync3_ff) ? sync3_ff : filt_ff;
    fall = filt_ff & ~nxt_filt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filt_ff <= `PTCR_PIN_IDLE;
    end else begin
      filt_ff <= nxt_filt;
    end
  end

  always_comb begin
    nxt_flag = flag_ff;
    if (bus.trig_sel) begin
      if (bus.sw_we) begin
        nxt_flag = bus.sw_val;
      end
      if (fall) begin
        nxt_flag = 1'b1;
      end
      if (bus.ack) begin
        nxt_flag = 1'b0;
      end
    end else begin
      // Level mode is not latched, a write has no lasting effect
      nxt_flag = ~filt_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_ff <= `PTCR_RST_BIT;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign bus.flag = flag_ff;
  assign bus.pin_low = ~filt_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  edge_set_flag_a: assert property (bus.trig_sel && fall && !bus.ack |=> flag_ff)
    else $error("edge fall did not set request flag");
  edge_ack_clear_a: assert property (bus.trig_sel && bus.ack |=> !flag_ff)
    else $error("acknowledge did not clear edge flag");
  level_follow_a: assert property (!bus.trig_sel |=> flag_ff == $past(bus.pin_low))
    else $error("level flag does not follow pin");
  edge_seen_c: cover property (bus.trig_sel && fall ##1 flag_ff);
endmodule : ptcr_ext_chan
`default_nettype wire

// ===== ptcr_regs.sv
// Port option, power control and timer/interrupt control register bank
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ptcr_cfg.svh"
// Summary of operation
// - Pull-up select 0 makes low port open-drain, 1 gives internal pull-ups.
// - Baud doubler bit doubles serial baud rate in serial modes 1, 2, 3.
// - Framing check enable picks frame error or mode bit for serial bit 7.
// - Power-on reset sets power-on flag; software may clear it by writing.
// - Writing 1 to the power-down request enters power-down mode.
// - Writing 1 to the sleep request enters idle mode.
// - Timer 1 overflow sets its flag; vector entry clears; software writes.
// - Timer 0 overflow sets its flag; vector entry clears; software writes.
// - Run bits switch timer 1 and timer 0 on when 1, off when 0.
// - Selected fall or low level on an interrupt pin sets its flag.
// - Edge-triggered request flag clears when its service routine begins.
// - Level-triggered request flag follows the pin, it is not latched.
// - Trigger select 1: 1 falling edge, 0 low level, for interrupt 1.
// - Trigger select 0: 1 falling edge, 0 low level, for interrupt 0.
// - Idle stops the processor clock only; any interrupt or reset leaves.
// - Power-down stops all clocks; left by reset or enabled pin interrupt.
// - Ordinary reset keeps power-on flag, initialises the other bits.
module ptcr_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_pulse,
  input wire logic [7:0] addr,
  input wire ptcr_pkg::ptcr_byte_t wdata,
  input wire logic we,
  input wire logic re,
  output var ptcr_pkg::ptcr_byte_t rdata,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic tmr0_ack,
  input wire logic tmr1_ack,
  input wire logic ext0_ack,
  input wire logic ext1_ack,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic ext0_wake_en,
  input wire logic ext1_wake_en,
  input wire logic irq_pending,
  input wire logic [1:0] serial_mode,
  input wire logic serial_mode_bit7,
  input wire logic frame_error_flag,
  output logic low_port_pullup_sel,
  output logic baud_doubler,
  output logic baud_x2_active,
  output logic framing_check_enable,
  output logic serial_control_bit7,
  output logic power_on_flag,
  output logic user_flag_a,
  output logic user_flag_b,
  output logic tmr0_run,
  output logic tmr1_run,
  output logic tmr0_overflow_flag,
  output logic tmr1_overflow_flag,
  output logic ext0_request_flag,
  output logic ext1_request_flag,
  output logic ext0_trigger_sel,
  output logic ext1_trigger_sel,
  output logic cpu_clk_stop,
  output logic osc_stop
);
  import ptcr_pkg::*;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off,
                                  input logic w);
    wr_hit = w && (a == off);
  endfunction : wr_hit

  logic wr_port_option;
  logic wr_power_control;
  logic wr_timer_ctrl_reg;
  logic pullup_ff;
  logic baud_doubler_ff;
  logic framing_check_enable_ff;
  logic pof_ff;
  logic gf1_ff;
  logic gf0_ff;
  logic tr1_ff;
  logic tr0_ff;
  logic it1_ff;
  logic it0_ff;
  logic tf1_ff;
  logic tf0_ff;
  logic nxt_tf1;
  logic nxt_tf0;
  logic baud_x2_ff;
  logic scon7_ff;
  logic wake;
  ptcr_pwr_e pwr_ff;
  ptcr_pwr_e nxt_pwr;
  logic cpu_stop_ff;
  logic osc_stop_ff;
  ptcr_byte_t port_option_rd;
  ptcr_byte_t power_control_rd;
  ptcr_byte_t timer_ctrl_reg_rd;
  ptcr_byte_t nxt_rdata;
  ptcr_byte_t rdata_ff;

  ptcr_ext_if ext_if0 ();
  ptcr_ext_if ext_if1 ();

  assign wr_port_option = wr_hit(addr, `PTCR_ADDR_PORT_OPTION, we);
  assign wr_power_control = wr_hit(addr, `PTCR_ADDR_POWER_CONTROL, we);
  assign wr_timer_ctrl_reg = wr_hit(addr, `PTCR_ADDR_TIMER_CTRL_REG, we);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pullup_ff <= `PTCR_RST_BIT;
    end else if (wr_port_option) begin
      pullup_ff <= wdata[`PTCR_PORT_OPTION_PULLUP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      baud_doubler_ff <= `PTCR_RST_BIT;
      framing_check_enable_ff <= `PTCR_RST_BIT;
      gf1_ff <= `PTCR_RST_BIT;
      gf0_ff <= `PTCR_RST_BIT;
    end else if (wr_power_control) begin
      baud_doubler_ff <= wdata[`PTCR_POWER_CONTROL_BAUD_DOUBLER_BIT];
      framing_check_enable_ff <= wdata[`PTCR_POWER_CONTROL_FRAMING_CHECK_ENABLE_BIT];
      gf1_ff <= wdata[`PTCR_POWER_CONTROL_GF1_BIT];
      gf0_ff <= wdata[`PTCR_POWER_CONTROL_GF0_BIT];
    end
  end

  // Kept out of the ordinary reset so software can tell cold from warm start
  always_ff @(posedge clk_sys) begin
    if (por_pulse) begin
      pof_ff <= 1'b1;
    end else if (wr_power_control && !rst) begin
      pof_ff <= wdata[`PTCR_POWER_CONTROL_POF_BIT];
    end
  end

  // Serial side effects are registered, so they trail the write by a cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      baud_x2_ff <= `PTCR_RST_BIT;
      scon7_ff <= `PTCR_RST_BIT;
    end else begin
      baud_x2_ff <= baud_doubler_ff && (serial_mode != `PTCR_SER_MODE0);
      scon7_ff <= framing_check_enable_ff ? frame_error_flag : serial_mode_bit7;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tr1_ff <= `PTCR_RST_BIT;
      tr0_ff <= `PTCR_RST_BIT;
      it1_ff <= `PTCR_RST_BIT;
      it0_ff <= `PTCR_RST_BIT;
    end else if (wr_timer_ctrl_reg) begin
      tr1_ff <= wdata[`PTCR_TIMER_CTRL_REG_TR1_BIT];
      tr0_ff <= wdata[`PTCR_TIMER_CTRL_REG_TR0_BIT];
      it1_ff <= wdata[`PTCR_TIMER_CTRL_REG_IT1_BIT];
      it0_ff <= wdata[`PTCR_TIMER_CTRL_REG_IT0_BIT];
    end
  end

  // Overflow beats a software write, acknowledge beats both
  always_comb begin
    nxt_tf1 = tf1_ff;
    nxt_tf0 = tf0_ff;
    if (wr_timer_ctrl_reg) begin
      nxt_tf1 = wdata[`PTCR_TIMER_CTRL_REG_TF1_BIT];
      nxt_tf0 = wdata[`PTCR_TIMER_CTRL_REG_TF0_BIT];
    end
    if (tmr1_ovf) begin
      nxt_tf1 = 1'b1;
    end
    if (tmr0_ovf) begin
      nxt_tf0 = 1'b1;
    end
    if (tmr1_ack) begin
      nxt_tf1 = 1'b0;
    end
    if (tmr0_ack) begin
      nxt_tf0 = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tf1_ff <= `PTCR_RST_BIT;
      tf0_ff <= `PTCR_RST_BIT;
    end else begin
      tf1_ff <= nxt_tf1;
      tf0_ff <= nxt_tf0;
    end
  end

  assign ext_if0.trig_sel = it0_ff;
  assign ext_if0.ack = ext0_ack;
  assign ext_if0.sw_we = wr_timer_ctrl_reg;
  assign ext_if0.sw_val = wdata[`PTCR_TIMER_CTRL_REG_IE0_BIT];
  assign ext_if1.trig_sel = it1_ff;
  assign ext_if1.ack = ext1_ack;
  assign ext_if1.sw_we = wr_timer_ctrl_reg;
  assign ext_if1.sw_val = wdata[`PTCR_TIMER_CTRL_REG_IE1_BIT];

  ptcr_ext_chan u_ext0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(ext_irq_pin_a),
    .bus(ext_if0.chan)
  );

  ptcr_ext_chan u_ext1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(ext_irq_pin_b),
    .bus(ext_if1.chan)
  );

  // Wake logic must sit on the always-on part of the clock tree
  assign wake = (ext0_wake_en && ext_if0.pin_low) ||
                (ext1_wake_en && ext_if1.pin_low);

  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PTCR_RUN: begin
        if (wr_power_control && wdata[`PTCR_POWER_CONTROL_PD_BIT]) begin
          nxt_pwr = PTCR_PDOWN;
        end else if (wr_power_control && wdata[`PTCR_POWER_CONTROL_IDL_BIT]) begin
          nxt_pwr = PTCR_IDLE;
        end
      end
      PTCR_IDLE: begin
        if (irq_pending) begin
          nxt_pwr = PTCR_RUN;
        end
      end
      PTCR_PDOWN: begin
        if (wake) begin
          nxt_pwr = PTCR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwr_ff <= PTCR_RUN;
      cpu_stop_ff <= `PTCR_RST_BIT;
      osc_stop_ff <= `PTCR_RST_BIT;
    end else begin
      pwr_ff <= nxt_pwr;
      cpu_stop_ff <= (nxt_pwr != PTCR_RUN);
      osc_stop_ff <= (nxt_pwr == PTCR_PDOWN);
    end
  end

  always_comb begin
    port_option_rd = `PTCR_RST_BYTE;
    port_option_rd[`PTCR_PORT_OPTION_PULLUP_BIT] = pullup_ff;
    power_control_rd = `PTCR_RST_BYTE;
    power_control_rd[`PTCR_POWER_CONTROL_BAUD_DOUBLER_BIT] = baud_doubler_ff;
    power_control_rd[`PTCR_POWER_CONTROL_FRAMING_CHECK_ENABLE_BIT] = framing_check_enable_ff;
    power_control_rd[`PTCR_POWER_CONTROL_POF_BIT] = pof_ff;
    power_control_rd[`PTCR_POWER_CONTROL_GF1_BIT] = gf1_ff;
    power_control_rd[`PTCR_POWER_CONTROL_GF0_BIT] = gf0_ff;
    power_control_rd[`PTCR_POWER_CONTROL_PD_BIT] = (pwr_ff == PTCR_PDOWN);
    power_control_rd[`PTCR_POWER_CONTROL_IDL_BIT] = (pwr_ff == PTCR_IDLE);
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_TF1_BIT] = tf1_ff;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_TR1_BIT] = tr1_ff;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_TF0_BIT] = tf0_ff;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_TR0_BIT] = tr0_ff;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_IE1_BIT] = ext_if1.flag;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_IT1_BIT] = it1_ff;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_IE0_BIT] = ext_if0.flag;
    timer_ctrl_reg_rd[`PTCR_TIMER_CTRL_REG_IT0_BIT] = it0_ff;
    nxt_rdata = `PTCR_RST_BYTE;
    if (re) begin
      if (addr == `PTCR_ADDR_PORT_OPTION) begin
        nxt_rdata = port_option_rd;
      end else if (addr == `PTCR_ADDR_POWER_CONTROL) begin
        nxt_rdata = power_control_rd;
      end else if (addr == `PTCR_ADDR_TIMER_CTRL_REG) begin
        nxt_rdata = timer_ctrl_reg_rd;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_ff <= `PTCR_RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign low_port_pullup_sel = pullup_ff;
  assign baud_doubler = baud_doubler_ff;
  assign baud_x2_active = baud_x2_ff;
  assign framing_check_enable = framing_check_enable_ff;
  assign serial_control_bit7 = scon7_ff;
  assign power_on_flag = pof_ff;
  assign user_flag_a = gf0_ff;
  assign user_flag_b = gf1_ff;
  assign tmr0_run = tr0_ff;
  assign tmr1_run = tr1_ff;
  assign tmr0_overflow_flag = tf0_ff;
  assign tmr1_overflow_flag = tf1_ff;
  assign ext0_request_flag = ext_if0.flag;
  assign ext1_request_flag = ext_if1.flag;
  assign ext0_trigger_sel = it0_ff;
  assign ext1_trigger_sel = it1_ff;
  assign cpu_clk_stop = cpu_stop_ff;
  assign osc_stop = osc_stop_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  pullup_write_a: assert property (wr_port_option |=> pullup_ff == $past(wdata[0]))
    else $error("pull-up select not taken from write");
  baud_double_a: assert property (##1 baud_x2_ff == $past(baud_doubler_ff &&
    serial_mode != 2'h0))
    else $error("baud doubling wrong for mode");
  scon7_mux_a: assert property (framing_check_enable_ff |=> scon7_ff == $past(frame_error_flag))
    else $error("serial bit 7 not frame error");
  pof_set_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    por_pulse |=> pof_ff)
    else $error("power-on flag not set");
  pof_keep_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst && !por_pulse |=> pof_ff == $past(pof_ff))
    else $error("ordinary reset changed power-on flag");
  pd_entry_a: assert property (pwr_ff == PTCR_RUN && wr_power_control && wdata[1]
    |=> osc_stop_ff && cpu_stop_ff)
    else $error("power-down not entered");
  idle_entry_a: assert property (pwr_ff == PTCR_RUN && wr_power_control && wdata[0] &&
    !wdata[1] |=> cpu_stop_ff && !osc_stop_ff)
    else $error("idle not entered");
  tf1_set_a: assert property (tmr1_ovf && !tmr1_ack |=> tf1_ff)
    else $error("timer 1 overflow flag not set");
  ack_wins_a: assert property (tmr0_ack |=> !tf0_ff)
    else $error("timer 0 acknowledge did not clear flag");
  run_bits_a: assert property (wr_timer_ctrl_reg |=> tr1_ff == $past(wdata[6]) &&
    tr0_ff == $past(wdata[4]))
    else $error("run bits not written");
  idle_exit_a: assert property (pwr_ff == PTCR_IDLE && irq_pending
    |=> !cpu_stop_ff)
    else $error("idle not left on interrupt");
  pd_hold_a: assert property (pwr_ff == PTCR_PDOWN && !wake
    |=> osc_stop_ff [*1])
    else $error("power-down left without wake");

  idle_cycle_c: cover property (pwr_ff == PTCR_IDLE ##[1:20] pwr_ff == PTCR_RUN);
  pd_wake_c: cover property (pwr_ff == PTCR_PDOWN && wake ##1 !osc_stop_ff);
  tf_set_c: cover property (tmr0_ovf ##1 tf0_ff ##[1:20] tmr0_ack);
  read_c: cover property (re && addr == `PTCR_ADDR_TIMER_CTRL_REG);
endmodule : ptcr_regs
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the control register bank
`timescale 1ns/10ps
`default_nettype none
`include "ptcr_cfg.svh"
module tb_top;
  import ptcr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por_pulse = 1'b1;
  logic [7:0] addr = 8'h00;
  ptcr_byte_t wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  ptcr_byte_t rdata;
  logic [5:0] ev = 6'h00;
  logic [1:0] pin_n = 2'h3;
  logic [1:0] wake_en = 2'h0;
  logic irq_pending = 1'b0;
  logic [1:0] serial_mode = 2'h0;
  logic serial_mode_bit7 = 1'b0;
  logic frame_error_flag = 1'b0;
  logic low_port_pullup_sel, baud_doubler, baud_x2_active;
  logic framing_check_enable, serial_control_bit7, power_on_flag;
  logic user_flag_a, user_flag_b, tmr0_run, tmr1_run;
  logic tmr0_overflow_flag, tmr1_overflow_flag;
  logic ext0_request_flag, ext1_request_flag;
  logic ext0_trigger_sel, ext1_trigger_sel, cpu_clk_stop, osc_stop;
  int n_errors = 0;
  int tests_run = 0;
  int i;

  always #10 clk_sys = ~clk_sys;

  ptcr_regs ptcr_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .por_pulse(por_pulse), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .tmr0_ack(ev[2]),
    .tmr1_ack(ev[3]), .ext0_ack(ev[4]), .ext1_ack(ev[5]),
    .ext_irq_pin_a(pin_n[0]), .ext_irq_pin_b(pin_n[1]),
    .ext0_wake_en(wake_en[0]), .ext1_wake_en(wake_en[1]),
    .irq_pending(irq_pending), .serial_mode(serial_mode),
    .serial_mode_bit7(serial_mode_bit7),
    .frame_error_flag(frame_error_flag),
    .low_port_pullup_sel(low_port_pullup_sel), .baud_doubler(baud_doubler),
    .baud_x2_active(baud_x2_active),
    .framing_check_enable(framing_check_enable),
    .serial_control_bit7(serial_control_bit7),
    .power_on_flag(power_on_flag), .user_flag_a(user_flag_a),
    .user_flag_b(user_flag_b), .tmr0_run(tmr0_run), .tmr1_run(tmr1_run),
    .tmr0_overflow_flag(tmr0_overflow_flag),
    .tmr1_overflow_flag(tmr1_overflow_flag),
    .ext0_request_flag(ext0_request_flag),
    .ext1_request_flag(ext1_request_flag),
    .ext0_trigger_sel(ext0_trigger_sel), .ext1_trigger_sel(ext1_trigger_sel),
    .cpu_clk_stop(cpu_clk_stop), .osc_stop(osc_stop));

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk8(input string what, input ptcr_byte_t e, input ptcr_byte_t g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input ptcr_byte_t d);
    @(posedge clk_sys);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    we <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input ptcr_byte_t e);
    @(posedge clk_sys);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    re <= 1'b0;
    #1;
    chk8("rdata", e, rdata);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 6'h00;
    #1;
  endtask : pulse

  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    rst <= 1'b1;
    por_pulse <= por;
    cyc(5);
    @(posedge clk_sys);
    rst <= 1'b0;
    por_pulse <= 1'b0;
    #1;
  endtask : do_reset

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end

  initial begin
    cyc(5);
    @(posedge clk_sys);
    rst <= 1'b0;
    por_pulse <= 1'b0;
    #1;
    chk1("power_on_flag", 1'b1, power_on_flag);
    rd(`PTCR_ADDR_POWER_CONTROL, 8'h10);
    rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'h00);
    rd(`PTCR_ADDR_PORT_OPTION, 8'h00);
    end_test("reset");

    wr(`PTCR_ADDR_PORT_OPTION, 8'hff);
    chk1("low_port_pullup_sel", 1'b1, low_port_pullup_sel);
    rd(`PTCR_ADDR_PORT_OPTION, 8'h01);
    wr(`PTCR_ADDR_PORT_OPTION, 8'h00);
    chk1("low_port_pullup_sel", 1'b0, low_port_pullup_sel);
    wr(8'h89, 8'hff);
    rd(8'h89, 8'h00);
    cyc(1);
    chk8("rdata after read", 8'h00, rdata);
    rd(`PTCR_ADDR_PORT_OPTION, 8'h00);
    end_test("port option");

    // Clearing the power-on flag by software also tests the user flags
    wr(`PTCR_ADDR_POWER_CONTROL, 8'hcc);
    rd(`PTCR_ADDR_POWER_CONTROL, 8'hcc);
    chk1("power_on_flag", 1'b0, power_on_flag);
    chk1("user_flag_a", 1'b1, user_flag_a);
    chk1("user_flag_b", 1'b1, user_flag_b);
    chk1("framing_check_enable", 1'b1, framing_check_enable);
    cyc(2);
    chk1("baud_x2_active", 1'b0, baud_x2_active);
    for (i = 1; i < 4; i++) begin
      serial_mode <= i[1:0];
      cyc(3);
      chk1("baud_x2_active", 1'b1, baud_x2_active);
    end
    frame_error_flag <= 1'b1;
    cyc(3);
    chk1("serial_control_bit7", 1'b1, serial_control_bit7);
    wr(`PTCR_ADDR_POWER_CONTROL, 8'h80);
    chk1("framing_check_enable", 1'b0, framing_check_enable);
    cyc(2);
    chk1("serial_control_bit7", 1'b0, serial_control_bit7);
    serial_mode_bit7 <= 1'b1;
    cyc(3);
    chk1("serial_control_bit7", 1'b1, serial_control_bit7);
    end_test("power control");

    wr(`PTCR_ADDR_POWER_CONTROL, 8'h94);
    do_reset(1'b0);
    rd(`PTCR_ADDR_POWER_CONTROL, 8'h10);
    chk1("baud_doubler", 1'b0, baud_doubler);
    end_test("ordinary reset");

    wr(`PTCR_ADDR_POWER_CONTROL, 8'h11);
    chk1("cpu_clk_stop", 1'b1, cpu_clk_stop);
    chk1("osc_stop", 1'b0, osc_stop);
    rd(`PTCR_ADDR_POWER_CONTROL, 8'h11);
    irq_pending <= 1'b1;
    cyc(2);
    chk1("cpu_clk_stop", 1'b0, cpu_clk_stop);
    irq_pending <= 1'b0;
    rd(`PTCR_ADDR_POWER_CONTROL, 8'h10);
    end_test("idle");

    // Power-down ignores a plain pending interrupt and a masked pin
    wr(`PTCR_ADDR_POWER_CONTROL, 8'h13);
    chk1("osc_stop", 1'b1, osc_stop);
    rd(`PTCR_ADDR_POWER_CONTROL, 8'h12);
    irq_pending <= 1'b1;
    pin_n[0] <= 1'b0;
    cyc(8);
    chk1("osc_stop", 1'b1, osc_stop);
    irq_pending <= 1'b0;
    wake_en[0] <= 1'b1;
    cyc(8);
    chk1("osc_stop", 1'b0, osc_stop);
    chk1("cpu_clk_stop", 1'b0, cpu_clk_stop);
    pin_n[0] <= 1'b1;
    wake_en[0] <= 1'b0;
    cyc(8);
    end_test("power down");

    wr(`PTCR_ADDR_TIMER_CTRL_REG, 8'h50);
    chk1("tmr1_run", 1'b1, tmr1_run);
    chk1("tmr0_run", 1'b1, tmr0_run);
    pulse(6'h02);
    rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'hd0);
    pulse(6'h08);
    chk1("tmr1_overflow_flag", 1'b0, tmr1_overflow_flag);
    pulse(6'h01);
    chk1("tmr0_overflow_flag", 1'b1, tmr0_overflow_flag);
    pulse(6'h05);
    chk1("tmr0_overflow_flag", 1'b0, tmr0_overflow_flag);
    pulse(6'h0a);
    chk1("tmr1_overflow_flag", 1'b0, tmr1_overflow_flag);
    wr(`PTCR_ADDR_TIMER_CTRL_REG, 8'hf0);
    rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'hf0);
    wr(`PTCR_ADDR_TIMER_CTRL_REG, 8'h00);
    rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'h00);
    end_test("timers");

    for (i = 0; i < 2; i++) begin
      wr(`PTCR_ADDR_TIMER_CTRL_REG, 8'h05);
      chk1("trigger_sel", 1'b1, i ? ext1_trigger_sel : ext0_trigger_sel);
      pin_n[i] <= 1'b0;
      cyc(8);
      chk1("request_flag", 1'b1, i ? ext1_request_flag : ext0_request_flag);
      rd(`PTCR_ADDR_TIMER_CTRL_REG, i ? 8'h0d : 8'h07);
      pin_n[i] <= 1'b1;
      cyc(8);
      rd(`PTCR_ADDR_TIMER_CTRL_REG, i ? 8'h0d : 8'h07);
      pulse(i ? 6'h20 : 6'h10);
      chk1("request_flag", 1'b0, i ? ext1_request_flag : ext0_request_flag);
      rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'h05);
      wr(`PTCR_ADDR_TIMER_CTRL_REG, 8'h00);
      pin_n[i] <= 1'b0;
      cyc(8);
      rd(`PTCR_ADDR_TIMER_CTRL_REG, i ? 8'h08 : 8'h02);
      pin_n[i] <= 1'b1;
      cyc(8);
      rd(`PTCR_ADDR_TIMER_CTRL_REG, 8'h00);
    end
    end_test("external interrupts");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
